// [design/viu_consts.svh]
// Offsets, field positions, reset values and timing counts of the interrupt unit
// Behaviour
// - Eleven sources plus reset, each own vector
// - Serve only with source and global enable
// - Vectors reset 0x000 through converter 0x00B
// - Lowest vector address wins among pending
// - Accepting an interrupt clears global enable
// - Return instruction sets global enable again
// - Steering to vector clears served flag
// - Writing one clears a flag; zero keeps
// - Disabled source still sets and keeps flag
// - Flags held while disabled, served by priority
// - Level external request has no stored flag
// - Entry four cycles, program counter pushed first
// - Vector jump to handler takes two cycles
// - Multi-cycle instruction finishes before entry
// - Return four cycles, program counter popped
// - One main instruction runs after return
// - Three eight-bit mask registers exist
// - Mask bits 6, 5, 4; reserved read zero
// - External flag clears; reads zero in level
// - Disabled group or alternate pin: no flag
`ifndef VIU_CONSTS_SVH
`define VIU_CONSTS_SVH

// ----------------------------------------
// Register indices (byte address = 4 x index)
// ----------------------------------------
`define IDX_GEN_MASK   6'h3b
`define IDX_GEN_FLAG   6'h3a
`define IDX_TMR_MASK   6'h39
`define IDX_TMR_FLAG   6'h38
`define IDX_AUX_FLAG   6'h3c
`define IDX_AUX_MASK   6'h3d
`define IDX_EXT_SENSE  6'h35
`define IDX_STATUS     6'h3f

// ----------------------------------------
// Field positions and implemented bits
// ----------------------------------------
`define GM_EXT         6
`define GM_PC_HI       5
`define GM_PC_LO       4
`define TM_CMPA        6
`define TM_CMPB        5
`define TM_OVF1        2
`define TM_OVF0        1
`define ST_GIE         7
`define GEN_MASK_BITS  8'h70
`define GEN_FLAG_BITS  8'h60
`define TMR_BITS       8'h66
`define AUX_BITS       8'h1f
`define SENSE_BITS     8'h03
`define REG_RESET      8'h00

// ----------------------------------------
// Vectors, sense modes, sizes and timing
// ----------------------------------------
`define VEC_RESET      10'h000
`define VEC_FIRST      10'h001
`define VEC_LAST       10'h00b
`define SENSE_LEVEL    2'h0
`define SENSE_ANY      2'h1
`define SENSE_FALL     2'h2
`define SENSE_RISE     2'h3
`define NUM_SRC        11
`define NUM_PC_PINS    11
`define PC_LO_PINS     4
`define ENTRY_CYCLES   3'h4
`define JUMP_CYCLES    3'h2
`define RETURN_CYCLES  3'h4

`endif

// [design/viu_pkg.sv]
// Types shared by the vectored interrupt unit
package viu_pkg;

	// Entry/return sequencer states
	typedef enum logic [1:0] {
		S_RUN,
		S_ENTRY,
		S_JUMP,
		S_RETURN
	} seq_state_t;

	// Peripheral event strobes, last field is lowest source
	typedef struct packed {
		logic conv_done_event;
		logic comparator_event;
		logic nvm_ready_event;
		logic serial_overflow_event;
		logic serial_start_event;
		logic timer0_ovf_event;
		logic timer1_ovf_event;
		logic timer1_cmp_b_event;
		logic timer1_cmp_a_event;
	} periph_events_t;

	// Commands to the core sequencer
	typedef struct packed {
		logic       hold;
		logic       push;
		logic       pop;
		logic       load;
		logic [9:0] saved_pc;
		logic [9:0] target;
	} core_cmd_t;

endpackage

// [design/vectored_interrupt_unit.sv]
// Vectored interrupt unit: flags, masks, arbiter, entry and return sequencer
//
// The Wishbone slave port was left to the implementer.
`timescale 1ns/100ps
`include "viu_consts.svh"

module vectored_interrupt_unit (
	input  wire logic                     clk_i,
	input  wire logic                     rst_i,
	input  wire logic                     wb_cyc_i,
	input  wire logic                     wb_stb_i,
	input  wire logic                     wb_we_i,
	input  wire logic [7:0]               wb_adr_i,
	input  wire logic [3:0]               wb_sel_i,
	input  wire logic [31:0]              wb_dat_i,
	output logic      [31:0]              wb_dat_o,
	output logic                          wb_ack_o,
	input  wire logic                     ext_pin_i,
	input  wire logic [`NUM_PC_PINS-1:0]  pc_pins_i,
	input  wire logic [`NUM_PC_PINS-1:0]  alt_func_i,
	input  wire viu_pkg::periph_events_t  events_i,
	input  wire logic                     boundary_i,
	input  wire logic                     return_from_irq_instr_i,
	input  wire logic [9:0]               pc_i,
	input  wire logic [9:0]               pop_data_i,
	output viu_pkg::core_cmd_t            core_cmd_o,
	output logic                          gie_o
);

	// ----------------------------------------
	// Functions
	// ----------------------------------------
	// Lowest set bit wins, as the vector table orders priority
	function automatic logic [3:0] lowest_src(input logic [`NUM_SRC-1:0] p);
		logic [3:0] r;
		r = 4'h0;
		for (int i = `NUM_SRC - 1; i >= 0; i--) begin
			if (p[i]) begin
				r = 4'(i);
			end
		end
		return r;
	endfunction
	// Source index to program vector, reset holds vector zero
	function automatic logic [9:0] vector_of(input logic [3:0] idx);
		logic [9:0] v;
		v = `VEC_FIRST + {6'h00, idx};
		if (v > `VEC_LAST) begin
			v = `VEC_RESET;
		end
		return v;
	endfunction

	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	logic [7:0]              gen_mask_reg;
	logic [7:0]              tmr_mask_reg;
	logic [7:0]              aux_mask_reg;
	logic [1:0]              sense_reg;
	logic                    gie_reg;
	logic                    gie_next;
	logic [`NUM_SRC-1:0]     flag_reg;
	logic [`NUM_SRC-1:0]     flag_next;
	logic [`NUM_SRC-1:0]     flag_set;
	logic [`NUM_SRC-1:0]     flag_clr;
	logic [`NUM_SRC-1:0]     sw_clr;
	logic [`NUM_SRC-1:0]     hw_clr;
	logic [`NUM_SRC-1:0]     src_en;
	logic [`NUM_SRC-1:0]     eff_flag;
	logic [`NUM_SRC-1:0]     pend;
	logic                    ext_s1_reg;
	logic                    ext_s2_reg;
	logic                    ext_prev_reg;
	logic [`NUM_PC_PINS-1:0] pc_s1_reg;
	logic [`NUM_PC_PINS-1:0] pc_s2_reg;
	logic [`NUM_PC_PINS-1:0] pc_prev_reg;
	logic [`NUM_PC_PINS-1:0] pc_group_en;
	logic                    level_mode;
	logic                    level_active;
	logic                    ext_edge;
	logic                    pc_change;
	viu_pkg::seq_state_t     state_reg;
	viu_pkg::seq_state_t     state_next;
	logic [2:0]              cnt_reg;
	logic [2:0]              cnt_next;
	logic [3:0]              src_reg;
	logic [3:0]              src_next;
	logic                    guard_reg;
	logic                    guard_next;
	viu_pkg::core_cmd_t      cmd_reg;
	viu_pkg::core_cmd_t      cmd_next;
	logic                    accept;
	logic                    serve_done;
	logic                    ret_done;
	logic                    wb_req;
	logic                    wb_wr;
	logic [5:0]              idx;
	logic [7:0]              wdat;
	logic [7:0]              rd_byte;
	logic                    ack_reg;
	logic [31:0]             dat_reg;

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	// Two flops before any logic; third stage only for edge compare
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ext_s1_reg   <= 1'b1;
			ext_s2_reg   <= 1'b1;
			ext_prev_reg <= 1'b1;
			pc_s1_reg    <= '0;
			pc_s2_reg    <= '0;
			pc_prev_reg  <= '0;
		end else begin
			ext_s1_reg   <= ext_pin_i;
			ext_s2_reg   <= ext_s1_reg;
			ext_prev_reg <= ext_s2_reg;
			pc_s1_reg    <= pc_pins_i;
			pc_s2_reg    <= pc_s1_reg;
			pc_prev_reg  <= pc_s2_reg;
		end
	end

	// ----------------------------------------
	// Event detection
	// ----------------------------------------
	// External request: low level or selected edge
	assign level_mode   = (sense_reg == `SENSE_LEVEL);
	assign level_active = level_mode & ~ext_s2_reg;
	assign ext_edge     = (sense_reg == `SENSE_ANY)  ? (ext_prev_reg ^ ext_s2_reg) :
	                      (sense_reg == `SENSE_FALL) ? (ext_prev_reg & ~ext_s2_reg) :
	                      (sense_reg == `SENSE_RISE) ? (~ext_prev_reg & ext_s2_reg) :
	                      1'b0;
	// Pin change, masked per group and per alternate-function pin
	assign pc_group_en = {{(`NUM_PC_PINS-`PC_LO_PINS){gen_mask_reg[`GM_PC_HI]}},
	                      {`PC_LO_PINS{gen_mask_reg[`GM_PC_LO]}}};
	assign pc_change   = |((pc_s2_reg ^ pc_prev_reg) & ~alt_func_i
	                       & pc_group_en);
	// Raw set strobes in source order (ext lowest)
	assign flag_set = {events_i, pc_change, ext_edge};

	// ----------------------------------------
	// Enables and software clears
	// ----------------------------------------
	assign wb_req = wb_cyc_i & wb_stb_i & ~ack_reg;
	assign wb_wr  = wb_req & wb_we_i & wb_sel_i[0];
	assign idx    = wb_adr_i[7:2];
	assign wdat   = wb_dat_i[7:0];
	// Individual enables in source order
	assign src_en = {aux_mask_reg[4:0],
	                 tmr_mask_reg[`TM_OVF0], tmr_mask_reg[`TM_OVF1],
	                 tmr_mask_reg[`TM_CMPB], tmr_mask_reg[`TM_CMPA],
	                 gen_mask_reg[`GM_PC_HI] | gen_mask_reg[`GM_PC_LO],
	                 gen_mask_reg[`GM_EXT]};
	// Write-one-to-clear, zero bits leave flags alone
	assign sw_clr[1:0]  = (wb_wr && idx == `IDX_GEN_FLAG) ?
	                      {wdat[`GM_PC_HI], wdat[`GM_EXT]} : 2'h0;
	assign sw_clr[5:2]  = (wb_wr && idx == `IDX_TMR_FLAG) ?
	                      {wdat[`TM_OVF0], wdat[`TM_OVF1],
	                       wdat[`TM_CMPB], wdat[`TM_CMPA]} : 4'h0;
	assign sw_clr[10:6] = (wb_wr && idx == `IDX_AUX_FLAG) ?
	                      wdat[4:0] : 5'h00;
	// Hardware clear of the served source when the vector is loaded
	assign hw_clr = serve_done ? (`NUM_SRC'(1) << src_reg) : '0;
	// Level mode keeps the external flag forced clear
	assign flag_clr = sw_clr | hw_clr | {{(`NUM_SRC-1){1'b0}}, level_mode};

	// ----------------------------------------
	// Flags: set wins over any clear in the same cycle
	// ----------------------------------------
	generate
		for (genvar g = 0; g < `NUM_SRC; g++) begin : g_flag
			assign flag_next[g] = flag_set[g] | (flag_reg[g] & ~flag_clr[g]);
		end
	endgenerate
	// Flags latch regardless of enables
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			flag_reg <= '0;
		end else begin
			flag_reg <= flag_next;
		end
	end

	// ----------------------------------------
	// Arbiter
	// ----------------------------------------
	// External level request stands in for its flag
	assign eff_flag = {flag_reg[`NUM_SRC-1:1],
	                   level_mode ? level_active : flag_reg[0]};
	assign pend     = eff_flag & src_en;
	// Only at an instruction boundary, never right after a return
	assign accept = (state_reg == viu_pkg::S_RUN) & boundary_i & gie_reg
	                & (|pend) & ~guard_reg;
	assign serve_done = (state_reg == viu_pkg::S_ENTRY) && (cnt_reg == 3'h0);
	assign ret_done   = (state_reg == viu_pkg::S_RETURN) && (cnt_reg == 3'h0);

	// ----------------------------------------
	// Entry and return sequencer
	// ----------------------------------------
	always_comb begin
		state_next    = state_reg;
		cnt_next      = cnt_reg;
		src_next      = src_reg;
		guard_next    = guard_reg;
		cmd_next      = cmd_reg;
		cmd_next.push = 1'b0;
		cmd_next.pop  = 1'b0;
		cmd_next.load = 1'b0;
		case (state_reg)
			viu_pkg::S_RUN: begin
				if (boundary_i) begin
					guard_next = 1'b0;
				end
				if (accept) begin
					src_next          = lowest_src(pend);
					state_next        = viu_pkg::S_ENTRY;
					cnt_next          = `ENTRY_CYCLES - 3'h1;
					cmd_next.hold     = 1'b1;
					cmd_next.push     = 1'b1;
					cmd_next.saved_pc = pc_i;
				end else if (return_from_irq_instr_i) begin
					state_next    = viu_pkg::S_RETURN;
					cnt_next      = `RETURN_CYCLES - 3'h1;
					cmd_next.hold = 1'b1;
					cmd_next.pop  = 1'b1;
				end
			end
			viu_pkg::S_ENTRY: begin
				cnt_next = cnt_reg - 3'h1;
				if (cnt_reg == 3'h0) begin
					// Vector executes only after the push cycles
					state_next      = viu_pkg::S_JUMP;
					cnt_next        = `JUMP_CYCLES - 3'h1;
					cmd_next.hold   = 1'b0;
					cmd_next.load   = 1'b1;
					cmd_next.target = vector_of(src_reg);
				end
			end
			viu_pkg::S_JUMP: begin
				// Relative jump at the vector runs in the core
				cnt_next = cnt_reg - 3'h1;
				if (cnt_reg == 3'h0) begin
					state_next = viu_pkg::S_RUN;
				end
			end
			viu_pkg::S_RETURN: begin
				cnt_next = cnt_reg - 3'h1;
				if (cnt_reg == 3'h0) begin
					state_next      = viu_pkg::S_RUN;
					cmd_next.hold   = 1'b0;
					cmd_next.load   = 1'b1;
					cmd_next.target = pop_data_i;
					guard_next      = 1'b1;
				end
			end
			default: begin
				state_next = viu_pkg::S_RUN;
			end
		endcase
	end

	// Sequencer registers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_reg <= viu_pkg::S_RUN;
			cnt_reg   <= 3'h0;
			src_reg   <= 4'h0;
			guard_reg <= 1'b0;
			cmd_reg   <= '{hold: 1'b0, push: 1'b0, pop: 1'b0, load: 1'b0,
			               saved_pc: 10'h000, target: `VEC_RESET};
		end else begin
			state_reg <= state_next;
			cnt_reg   <= cnt_next;
			src_reg   <= src_next;
			guard_reg <= guard_next;
			cmd_reg   <= cmd_next;
		end
	end

	// ----------------------------------------
	// Global enable
	// ----------------------------------------
	// Hardware events outrank a software write in the same cycle;
	// only the enable bit is kept, the rest of the status byte is not
	always_comb begin
		gie_next = gie_reg;
		if (wb_wr && idx == `IDX_STATUS) begin
			gie_next = wdat[`ST_GIE];
		end
		if (ret_done) begin
			gie_next = 1'b1;
		end
		if (accept) begin
			gie_next = 1'b0;
		end
	end

	// ----------------------------------------
	// Register file
	// ----------------------------------------
	// Masks and sense select; reserved bits never store
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			gen_mask_reg <= `REG_RESET;
			tmr_mask_reg <= `REG_RESET;
			aux_mask_reg <= `REG_RESET;
			sense_reg    <= `SENSE_LEVEL;
			gie_reg      <= 1'b0;
		end else begin
			gie_reg <= gie_next;
			if (wb_wr && idx == `IDX_GEN_MASK) begin
				gen_mask_reg <= wdat & `GEN_MASK_BITS;
			end
			if (wb_wr && idx == `IDX_TMR_MASK) begin
				tmr_mask_reg <= wdat & `TMR_BITS;
			end
			if (wb_wr && idx == `IDX_AUX_MASK) begin
				aux_mask_reg <= wdat & `AUX_BITS;
			end
			if (wb_wr && idx == `IDX_EXT_SENSE) begin
				sense_reg <= wdat[1:0];
			end
		end
	end

	// Read decode; unmapped indices read zero
	always_comb begin
		rd_byte = 8'h00;
		if (idx == `IDX_GEN_MASK) begin
			rd_byte = gen_mask_reg;
		end else if (idx == `IDX_GEN_FLAG) begin
			rd_byte = {1'b0, eff_flag[0] & ~level_mode, flag_reg[1], 5'h00};
		end else if (idx == `IDX_TMR_MASK) begin
			rd_byte = tmr_mask_reg;
		end else if (idx == `IDX_TMR_FLAG) begin
			rd_byte = {1'b0, flag_reg[2], flag_reg[3], 2'h0,
			           flag_reg[4], flag_reg[5], 1'b0};
		end else if (idx == `IDX_AUX_FLAG) begin
			rd_byte = {3'h0, flag_reg[10:6]};
		end else if (idx == `IDX_AUX_MASK) begin
			rd_byte = aux_mask_reg;
		end else if (idx == `IDX_EXT_SENSE) begin
			rd_byte = {6'h00, sense_reg};
		end else if (idx == `IDX_STATUS) begin
			rd_byte = {gie_reg, 7'h00};
		end
	end

	// ----------------------------------------
	// Wishbone answer
	// ----------------------------------------
	// One wait state; ack drops the cycle after it is given
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_reg <= 1'b0;
			dat_reg <= 32'h0000_0000;
		end else begin
			ack_reg <= wb_req;
			dat_reg <= wb_req ? {24'h00_0000, rd_byte} : 32'h0000_0000;
		end
	end
	// Outputs straight from their flops
	assign wb_ack_o   = ack_reg;
	assign wb_dat_o   = dat_reg;
	assign core_cmd_o = cmd_reg;
	assign gie_o      = gie_reg;

endmodule

// [testbench/viu_props.sv]
// Port checker for the vectored interrupt unit
`timescale 1ns/100ps
`include "viu_consts.svh"
module viu_props (
	input wire logic                    clk_i,
	input wire logic                    rst_i,
	input wire logic                    wb_cyc_i,
	input wire logic                    wb_stb_i,
	input wire logic                    wb_we_i,
	input wire logic [7:0]              wb_adr_i,
	input wire logic [3:0]              wb_sel_i,
	input wire logic [31:0]             wb_dat_i,
	input wire logic [31:0]             wb_dat_o,
	input wire logic                    wb_ack_o,
	input wire logic                    ext_pin_i,
	input wire logic [`NUM_PC_PINS-1:0] pc_pins_i,
	input wire logic [`NUM_PC_PINS-1:0] alt_func_i,
	input wire viu_pkg::periph_events_t events_i,
	input wire logic                    boundary_i,
	input wire logic                    return_from_irq_instr_i,
	input wire logic [9:0]              pc_i,
	input wire logic [9:0]              pop_data_i,
	input wire viu_pkg::core_cmd_t      core_cmd_o,
	input wire logic                    gie_o
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	// ----------------------------------------
	// Entry, jump and return sequencing
	// ----------------------------------------
	// Core stalls exactly four cycles, then loads
	entry_four_a: assert property (
		core_cmd_o.push |-> core_cmd_o.hold [*4]
		##1 (core_cmd_o.load && !core_cmd_o.hold))
		else $error("entry not four cycles");
	entry_gie_a: assert property (
		core_cmd_o.push |-> !gie_o)
		else $error("global enable kept on accept");
	vector_range_a: assert property (
		core_cmd_o.push |-> ##4 (core_cmd_o.target >= `VEC_FIRST
		&& core_cmd_o.target <= `VEC_LAST))
		else $error("vector out of range");
	// Vector jump must finish before a new accept
	jump_gap_a: assert property (
		core_cmd_o.push ##4 core_cmd_o.load |-> !core_cmd_o.push [*3])
		else $error("accept inside vector jump");
	ret_four_a: assert property (
		core_cmd_o.pop |-> core_cmd_o.hold [*4]
		##1 (core_cmd_o.load && !core_cmd_o.hold && gie_o))
		else $error("return not four cycles");
	ret_one_instr_a: assert property (
		core_cmd_o.pop ##4 core_cmd_o.load |-> !core_cmd_o.push [*2])
		else $error("accept right after return");
	accept_cause_a: assert property (
		core_cmd_o.push |-> $past(boundary_i) && $past(gie_o))
		else $error("accept without boundary and enable");
	// Enable only comes back by a bus write or a return
	gie_source_a: assert property (
		$rose(gie_o) |-> wb_ack_o || $past(core_cmd_o.pop, 4))
		else $error("global enable set from nowhere");
	ack_pulse_a: assert property (
		wb_ack_o |-> $past(wb_stb_i) ##1 !wb_ack_o)
		else $error("bad acknowledge");
	dat_upper_a: assert property (
		wb_ack_o |-> wb_dat_o[31:8] == 24'h000000)
		else $error("upper read bits not zero");
	entry_c: cover property (core_cmd_o.push);
	return_c: cover property (core_cmd_o.pop ##4 core_cmd_o.load);
	ext_c: cover property (core_cmd_o.load && core_cmd_o.target == 10'h001);
endmodule

bind vectored_interrupt_unit viu_props u_props (.clk_i, .rst_i,
	.wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
	.wb_dat_o, .wb_ack_o, .ext_pin_i, .pc_pins_i, .alt_func_i,
	.events_i, .boundary_i, .return_from_irq_instr_i, .pc_i, .pop_data_i, .core_cmd_o,
	.gie_o);

// [testbench/core_model.sv]
// Core model: program counter, return stack, instruction pacing
`timescale 1ns/100ps
module core_model (
	input  wire logic               clk_i,
	input  wire logic               rst_i,
	input  wire viu_pkg::core_cmd_t cmd_i,
	input  wire logic               slow_i,
	input  wire logic               ret_req_i,
	output logic                    boundary_o,
	output logic                    return_from_irq_instr_o,
	output logic [9:0]              pc_o,
	output logic [9:0]              pop_data_o
);
	logic [9:0] stack_reg [16];
	logic [3:0] sp_reg;
	logic [1:0] busy_reg;
	logic       popping_reg;
	logic [9:0] top_w;
	// ----------------------------------------
	// Pacing and stack
	// ----------------------------------------
	// Slow instructions keep the next boundary off two cycles
	assign boundary_o = !cmd_i.hold && busy_reg == 2'h0;
	assign top_w = stack_reg[sp_reg - 4'h1];
	// Stale stack word shows inverted outside a pop
	assign pop_data_o = popping_reg ? top_w : ~top_w;
	// Status is never stacked: handlers keep it themselves
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pc_o <= 10'h000;
			sp_reg <= 4'h0;
			busy_reg <= 2'h0;
			popping_reg <= 1'b0;
			return_from_irq_instr_o <= 1'b0;
		end else begin
			return_from_irq_instr_o <= ret_req_i;
			if (boundary_o) begin
				pc_o <= pc_o + 10'h001;
				busy_reg <= slow_i ? 2'h2 : 2'h0;
			end else if (busy_reg != 2'h0 && !cmd_i.hold) begin
				busy_reg <= busy_reg - 2'h1;
			end
			if (cmd_i.push) begin
				stack_reg[sp_reg] <= cmd_i.saved_pc;
				sp_reg <= sp_reg + 4'h1;
			end
			if (cmd_i.pop) begin
				popping_reg <= 1'b1;
			end
			if (cmd_i.load) begin
				pc_o <= cmd_i.target;
				popping_reg <= 1'b0;
				if (popping_reg) begin
					sp_reg <= sp_reg - 4'h1;
				end
			end
		end
	end
endmodule

// [testbench/vectored_interrupt_unit_tb.sv]
// Self-checking bench for the vectored interrupt unit
`timescale 1ns/100ps
`include "viu_consts.svh"
module vectored_interrupt_unit_tb;
	logic                    clk_i, rst_i, cyc, stb, we, ext_pin;
	logic                    slow, ret_req, ack_w, gie_w, bnd_w, return_from_irq_instr_w;
	logic [7:0]              adr, q;
	logic [31:0]             wdat, rdat_w, seed;
	logic [10:0]             pins, alt;
	logic [9:0]              pc_w, pop_w, pc_last;
	viu_pkg::periph_events_t ev;
	viu_pkg::core_cmd_t      cmd;
	logic [9:0]              ret_q [$];
	int                      error_cnt, n_tests;
	logic [5:0] w_idx [4] = '{`IDX_GEN_MASK, `IDX_TMR_MASK,
		`IDX_AUX_MASK, 6'h10};
	logic [7:0] w_exp [4] = '{8'h70, 8'h66, 8'h1f, 8'h00};

	vectored_interrupt_unit dut (.clk_i(clk_i), .rst_i(rst_i),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(4'h1), .wb_dat_i(wdat), .wb_dat_o(rdat_w),
		.wb_ack_o(ack_w), .ext_pin_i(ext_pin), .pc_pins_i(pins),
		.alt_func_i(alt), .events_i(ev), .boundary_i(bnd_w),
		.return_from_irq_instr_i(return_from_irq_instr_w), .pc_i(pc_w), .pop_data_i(pop_w),
		.core_cmd_o(cmd), .gie_o(gie_w));
	core_model model (.clk_i(clk_i), .rst_i(rst_i), .cmd_i(cmd),
		.slow_i(slow), .ret_req_i(ret_req), .boundary_o(bnd_w),
		.return_from_irq_instr_o(return_from_irq_instr_w), .pc_o(pc_w), .pop_data_o(pop_w));
	// ----------------------------------------
	// Helpers and compares
	// ----------------------------------------
	function logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	// Timer flag image of a pending set, sources 2 to 5
	function logic [7:0] tflags(input logic [8:0] p);
		return {1'b0, p[0], p[1], 2'b00, p[2], p[3], 1'b0};
	endfunction
	function int lowest(input logic [8:0] p);
		lowest = 0;
		for (int i = 8; i >= 0; i--) begin
			if (p[i]) lowest = i;
		end
	endfunction
	task chk_reg(input string n, input logic [7:0] e, g);
		n_tests++;
		if (g !== e) begin
			error_cnt++;
			$display("Error %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic chk_adr(input string n, input logic [9:0] e, g);
		n_tests++;
		if (g !== e) begin
			error_cnt++;
			$display("Error %s exp %h got %h", n, e, g);
		end
	endtask
	task chk_bit(input string n, input logic e, g);
		n_tests++;
		if (g !== e) begin
			error_cnt++;
			$display("Error %s exp %b got %b", n, e, g);
		end
	endtask
	// One classic cycle, held until ack is sampled high
	task wb_xfer(input logic w, input logic [5:0] i, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= {i, 2'b00};
		wdat <= {24'h000000, d};
		do begin
			@(posedge clk_i);
			n++;
		end while (ack_w !== 1'b1 && n < 50);
		if (ack_w !== 1'b1) error_cnt++;
		q = rdat_w[7:0];
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
	task wait_load();
		int n;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (cmd.load !== 1'b1 && n < 300);
		if (cmd.load !== 1'b1) error_cnt++;
	endtask
	// Handler end: return instruction, then check the popped address
	task give_back();
		repeat (2) @(posedge clk_i);
		ret_req <= 1'b1;
		@(posedge clk_i);
		ret_req <= 1'b0;
		wait_load();
		chk_adr("return_pc", ret_q.pop_back(), cmd.target);
		chk_bit("gie_after_ret", 1'b1, gie_w);
	endtask
	// Pile flags up with enable off, then serve them by priority
	task pile_up(input logic [8:0] p);
		int k;
		ev <= viu_pkg::periph_events_t'(p);
		@(posedge clk_i);
		ev <= '0;
		wb_xfer(1'b0, `IDX_TMR_FLAG, 8'h00);
		chk_reg("timer_flags", tflags(p), q);
		wb_xfer(1'b0, `IDX_AUX_FLAG, 8'h00);
		chk_reg("aux_flags", {3'h0, p[8:4]}, q);
		wb_xfer(1'b1, `IDX_STATUS, 8'h80); // Software enable
		while (p != 9'h000) begin
			k = lowest(p);
			wait_load();
			chk_adr("vector", 10'(k + 3), cmd.target);
			chk_bit("gie_in_handler", 1'b0, gie_w);
			p[k] = 1'b0;
			slow <= seed[0];
			give_back();
			seed = xs();
		end
		wb_xfer(1'b0, `IDX_TMR_FLAG, 8'h00);
		chk_reg("served_flags", 8'h00, q);
		wb_xfer(1'b0, `IDX_AUX_FLAG, 8'h00);
		chk_reg("served_aux", 8'h00, q);
	endtask
	task close_out();
		$display("errors %0d tests %0d", error_cnt, n_tests);
		if (error_cnt == 0 && n_tests > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	// ----------------------------------------
	// Clock, monitor, watchdog and scenarios
	// ----------------------------------------
	initial begin
		clk_i = 1'b0;
		forever #50 clk_i = ~clk_i;
	end
	// Expected return address is the model's pc at the accept cycle
	always @(posedge clk_i) begin
		pc_last <= pc_w;
		if (cmd.push === 1'b1) begin
			chk_adr("saved_pc", pc_last, cmd.saved_pc);
			ret_q.push_back(pc_last);
		end
	end
	initial begin
		repeat (20000) @(posedge clk_i);
		error_cnt++;
		close_out();
	end
	initial begin
		{rst_i, ext_pin} = 2'b11;
		{cyc, stb, we, slow, ret_req} = 5'h00;
		{adr, wdat, pins, alt, ev} = '0;
		{error_cnt, n_tests} = 0;
		seed = 32'h0000001e;
		repeat (6) @(posedge clk_i);
		rst_i <= 1'b0;
		// Reserved bits and unmapped places read zero
		for (int i = 0; i < 4; i++) begin
			wb_xfer(1'b0, w_idx[i], 8'h00);
			chk_reg("reset_value", 8'h00, q);
			wb_xfer(1'b1, w_idx[i], 8'hff);
			wb_xfer(1'b0, w_idx[i], 8'h00);
			chk_reg("mask_readback", w_exp[i], q);
		end
		// Pin change: alternate pin and disabled group stay silent
		wb_xfer(1'b1, `IDX_GEN_MASK, 8'h10);
		alt <= 11'h001;
		pins <= 11'h011;
		repeat (4) @(posedge clk_i); // Let the change pass the synchroniser
		wb_xfer(1'b0, `IDX_GEN_FLAG, 8'h00);
		chk_reg("pc_flag_masked", 8'h00, q);
		pins <= 11'h013;
		repeat (4) @(posedge clk_i); // Flag must stand before the zero write
		wb_xfer(1'b1, `IDX_GEN_FLAG, 8'h00);
		wb_xfer(1'b0, `IDX_GEN_FLAG, 8'h00);
		chk_reg("pc_flag_zero_wr", 8'h20, q);
		wb_xfer(1'b1, `IDX_GEN_FLAG, 8'h20);
		wb_xfer(1'b0, `IDX_GEN_FLAG, 8'h00);
		chk_reg("pc_flag_one_wr", 8'h00, q);
		// Falling edge stores the external flag; writing one clears it
		wb_xfer(1'b1, `IDX_EXT_SENSE, {6'h00, `SENSE_FALL});
		ext_pin <= 1'b0;
		repeat (4) @(posedge clk_i);
		ext_pin <= 1'b1;
		wb_xfer(1'b0, `IDX_GEN_FLAG, 8'h00);
		chk_reg("ext_flag_edge", 8'h40, q);
		wb_xfer(1'b1, `IDX_GEN_FLAG, 8'h40);
		wb_xfer(1'b0, `IDX_GEN_FLAG, 8'h00);
		chk_reg("ext_flag_one_wr", 8'h00, q);
		wb_xfer(1'b1, `IDX_EXT_SENSE, 8'h00);
		// Random pile, then all nine peripheral sources at once
		pile_up(9'(xs()) | 9'h001);
		wb_xfer(1'b1, `IDX_STATUS, 8'h00);
		pile_up(9'h1ff);
		// Level external request, no stored flag
		wb_xfer(1'b1, `IDX_GEN_MASK, 8'h40);
		ext_pin <= 1'b0;
		wait_load();
		chk_adr("ext_vector", 10'h001, cmd.target);
		wb_xfer(1'b0, `IDX_GEN_FLAG, 8'h00);
		chk_reg("ext_flag_level", 8'h00, q);
		ext_pin <= 1'b1;
		give_back();
		close_out();
	end
endmodule
